// File: include/sip_pkg.sv
// Shared constants and types for the eight-stage serial-in, parallel-out shift register.
// Assumes every input is synchronous to the system clock.

package sip_pkg;

    // ****************************************
    // Geometry and reset values
    // ****************************************
    localparam int unsigned SIP_NUM_STAGES = 8;
    localparam int unsigned SIP_FIRST_STAGE = 0;
    localparam int unsigned SIP_LAST_STAGE = SIP_NUM_STAGES - 1;
    localparam logic [SIP_NUM_STAGES-1:0] SIP_STAGES_RST = 8'h00;
    localparam logic SIP_CLK_PREV_RST = 1'b1;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned SIP_CLK_PERIOD_PS = 5000;
    localparam int unsigned SIP_EDGE_LATENCY_CYC = 1;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic serial_in_a;
        logic serial_in_b;
    } sip_serial_s;

    typedef struct packed {
        logic [SIP_NUM_STAGES-1:0] stages;
    } sip_state_s;

    typedef struct packed {
        logic clk_prev;
    } sip_edge_state_s;

endpackage

// File: hw/sip_edge_det.sv
// Rising edge detector for the sampled shift clock.
// Assumes shift_clock_i is already synchronous to clk_sys_i.

`timescale 1ns/1ps

module sip_edge_det
    import sip_pkg::*;
(
    // System
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    // Sampled clock level
    input  wire logic shift_clock_i,
    // Edge pulse
    output logic      rise_o
);

    // ****************************************
    // State
    // ****************************************
    sip_edge_state_s state_reg;
    sip_edge_state_s state_next;

    always_comb begin
        state_next          = state_reg;
        state_next.clk_prev = shift_clock_i;
    end

    // Previous level resets high so a clock already high at release is no edge
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_reg.clk_prev <= SIP_CLK_PREV_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rise_o = shift_clock_i & ~state_reg.clk_prev;

endmodule

// File: hw/sip_shift_reg.sv
// Eight-stage serial-in, parallel-out shift register with gated serial inputs.
// Assumes all inputs are synchronous to clk_sys_i and the shift clock is much
// slower than the system clock.

`timescale 1ns/1ps

module sip_shift_reg
    import sip_pkg::*;
#(
    parameter int unsigned NUM_STAGES = SIP_NUM_STAGES
)
(
    // System
    input  wire logic                  clk_sys_i,
    input  wire logic                  srst_i,
    // Serial entry
    input  wire logic                  serial_in_a_i,
    input  wire logic                  serial_in_b_i,
    input  wire logic                  shift_clock_i,
    input  wire logic                  master_clear_n_i,
    // Parallel stages
    output logic [NUM_STAGES-1:0]      parallel_out_o
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (NUM_STAGES != SIP_NUM_STAGES) begin : g_bad_stages
        $error("NUM_STAGES must match the stage count of the shared state type");
    end

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic gated_data(input sip_serial_s s);
        gated_data = s.serial_in_a & s.serial_in_b;
    endfunction

    // ****************************************
    // Edge detection
    // ****************************************
    logic        shift_rise;
    sip_serial_s serial_bus;

    assign serial_bus.serial_in_a = serial_in_a_i;
    assign serial_bus.serial_in_b = serial_in_b_i;

    sip_edge_det sip_edge_det_i (
        .clk_sys_i     (clk_sys_i),
        .srst_i        (srst_i),
        .shift_clock_i (shift_clock_i),
        .rise_o        (shift_rise)
    );

    // ****************************************
    // Stage chain
    // ****************************************
    sip_state_s state_reg;
    sip_state_s state_next;
    logic [NUM_STAGES-1:0] shifted;

    assign shifted[SIP_FIRST_STAGE] = gated_data(serial_bus);

    // Each stage from 1 up takes its predecessor; the last stage's old bit falls off
    for (genvar i = 1; i < NUM_STAGES; i++) begin : g_chain
        assign shifted[i] = state_reg.stages[i-1];
    end

    always_comb begin
        state_next = state_reg;
        if (!master_clear_n_i) begin
            state_next.stages = SIP_STAGES_RST;
        end else if (shift_rise) begin
            state_next.stages = shifted;
        end
    end

    // Outputs stay put between shift edges, unless master clear is low, whatever the serial inputs do
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_reg.stages <= SIP_STAGES_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign parallel_out_o = state_reg.stages;

    // ****************************************
    // Assertions
    // ****************************************
    logic [NUM_STAGES-1:0] last_dropped;

    assign last_dropped = {state_reg.stages[NUM_STAGES-2:0], 1'b0};

    property p_shift_moves;
        @(posedge clk_sys_i) disable iff (srst_i)
        (shift_rise && master_clear_n_i)
        |=> (parallel_out_o[NUM_STAGES-1:1] == $past(parallel_out_o[NUM_STAGES-2:0]));
    endproperty
    a_shift_moves: assert property (p_shift_moves)
        else $error("Stages did not move one place on a shift edge");

    property p_first_and;
        @(posedge clk_sys_i) disable iff (srst_i)
        (shift_rise && master_clear_n_i)
        |=> (parallel_out_o[0] == ($past(serial_in_a_i) & $past(serial_in_b_i)));
    endproperty
    a_first_and: assert property (p_first_and)
        else $error("First stage did not load the AND of the serial inputs");

    property p_gate_low;
        @(posedge clk_sys_i) disable iff (srst_i)
        (shift_rise && (!serial_in_a_i || !serial_in_b_i))
        |=> !parallel_out_o[0];
    endproperty
    a_gate_low: assert property (p_gate_low)
        else $error("A low serial input failed to gate a zero in");

    property p_clear_wins;
        @(posedge clk_sys_i) disable iff (srst_i)
        !master_clear_n_i |=> (parallel_out_o == '0);
    endproperty
    a_clear_wins: assert property (p_clear_wins)
        else $error("Stages not cleared while master clear low");

    property p_clear_holds;
        @(posedge clk_sys_i) disable iff (srst_i)
        (!master_clear_n_i [*3]) |=> (parallel_out_o == '0) && !parallel_out_o[0];
    endproperty
    a_clear_holds: assert property (p_clear_holds)
        else $error("Stages moved during a held clear");

    property p_no_edge_no_change;
        @(posedge clk_sys_i) disable iff (srst_i)
        (!shift_rise && master_clear_n_i) |=> $stable(parallel_out_o);
    endproperty
    a_no_edge_no_change: assert property (p_no_edge_no_change)
        else $error("Outputs changed without a shift edge");

    property p_serial_only_no_effect;
        @(posedge clk_sys_i) disable iff (srst_i)
        (!shift_clock_i && master_clear_n_i && $changed(serial_in_a_i))
        |=> $stable(parallel_out_o);
    endproperty
    a_serial_only_no_effect: assert property (p_serial_only_no_effect)
        else $error("Serial input change reached the outputs directly");

    property p_last_dropped;
        @(posedge clk_sys_i) disable iff (srst_i)
        (shift_rise && master_clear_n_i && !serial_in_a_i)
        |=> (parallel_out_o == $past(last_dropped));
    endproperty
    a_last_dropped: assert property (p_last_dropped)
        else $error("Last stage bit was not discarded on a shift");

    property p_resume_after_clear;
        @(posedge clk_sys_i) disable iff (srst_i)
        (!master_clear_n_i ##1 (master_clear_n_i && shift_rise
                                && serial_in_a_i && serial_in_b_i))
        |=> (parallel_out_o == {{(NUM_STAGES-1){1'b0}}, 1'b1});
    endproperty
    a_resume_after_clear: assert property (p_resume_after_clear)
        else $error("Shifting did not resume on the first edge after clear");

    // Whole eight-stage vector after a shift: old stages moved up, new bit in stage 0
    property p_width_eight;
        @(posedge clk_sys_i) disable iff (srst_i)
        (master_clear_n_i && shift_rise)
        |=> (parallel_out_o == {$past(parallel_out_o[NUM_STAGES-2:0]),
                                $past(serial_in_a_i & serial_in_b_i)});
    endproperty
    a_width_eight: assert property (p_width_eight)
        else $error("Eight-stage vector did not take a full shift");

endmodule

// File: tb/sip_upstream_model.sv
// Upstream logic model driving the serial side of the shift register.
// Assumes a 5 ns system clock; inputs move 1 ns after its rising edge.
`timescale 1ns/1ps
module sip_upstream_model
    import sip_pkg::*;
(
    // System
    input  wire logic clk_sys_i,
    // Serial side
    output logic      serial_in_a_o,
    output logic      serial_in_b_o,
    output logic      shift_clock_o,
    output logic      master_clear_n_o
);
    // ****************************************
    // Drive tasks
    // ****************************************
    initial begin
        serial_in_a_o = 1'b0;
        serial_in_b_o = 1'b1;
        shift_clock_o = 1'b0;
        master_clear_n_o = 1'b1;
    end

    // One shift clock pulse, three cycles per shift
    task automatic shift_bit(input logic a, input logic b, input logic clr_n);
        @(posedge clk_sys_i) #1;
        serial_in_a_o = a;
        serial_in_b_o = b;
        shift_clock_o = 1'b1;
        master_clear_n_o = clr_n;
        @(posedge clk_sys_i) #1;
        shift_clock_o = 1'b0;
        master_clear_n_o = 1'b1;
        // Data no longer held: show the inverse on serial_in_a_o only
        serial_in_a_o = ~a;
        @(posedge clk_sys_i) #1;
    endtask

    // Clear held for n cycles while the shift clock toggles, then one shift when n is odd
    task automatic clear_hold(input int n, input logic a);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_i) #1;
            master_clear_n_o = 1'b0;
            shift_clock_o = i[0];
            serial_in_a_o = 1'b1;
            serial_in_b_o = 1'b1;
        end
        @(posedge clk_sys_i) #1;
        master_clear_n_o = 1'b1;
        shift_clock_o = 1'b1;
        serial_in_a_o = a;
        @(posedge clk_sys_i) #1;
        shift_clock_o = 1'b0;
        @(posedge clk_sys_i) #1;
    endtask

    // Shift clock held at one level while data toggles
    task automatic drive_run(input logic sc, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_i) #1;
            shift_clock_o = sc;
            serial_in_a_o = i[0];
        end
    endtask
endmodule

// File: tb/sip_shift_reg_tb.sv
// Self-checking bench for the eight-stage shift register.
// Assumes the upstream model in its own file drives every serial input.
`timescale 1ns/1ps
module sip_shift_reg_tb;
    import sip_pkg::*;
    logic                      clk_sys_i;
    logic                      srst_i;
    logic                      serial_in_a_i;
    logic                      serial_in_b_i;
    logic                      shift_clock_i;
    logic                      master_clear_n_i;
    logic [SIP_NUM_STAGES-1:0] parallel_out_o;
    int                        n_errors = 0;
    int                        n_checks = 0;
    // Rows: {a, b, expected stages}
    logic [9:0] rows [10] = '{10'h301, 10'h202, 10'h305, 10'h10A, 10'h014,
                              10'h329, 10'h353, 10'h2A6, 10'h34D, 10'h39B};

    sip_shift_reg sip_shift_reg_i (
        .clk_sys_i        (clk_sys_i),
        .srst_i           (srst_i),
        .serial_in_a_i    (serial_in_a_i),
        .serial_in_b_i    (serial_in_b_i),
        .shift_clock_i    (shift_clock_i),
        .master_clear_n_i (master_clear_n_i),
        .parallel_out_o   (parallel_out_o)
    );
    sip_upstream_model sip_upstream_model_i (
        .clk_sys_i        (clk_sys_i),
        .serial_in_a_o    (serial_in_a_i),
        .serial_in_b_o    (serial_in_b_i),
        .shift_clock_o    (shift_clock_i),
        .master_clear_n_o (master_clear_n_i)
    );

    // ****************************************
    // Clock, compare, verdict
    // ****************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        final_report();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        srst_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1 srst_i = 1'b0;
        check(parallel_out_o, 8'h00, "reset");
        $display("test reset done");
        foreach (rows[i]) begin
            sip_upstream_model_i.shift_bit(rows[i][9], rows[i][8], 1'b1);
            check(parallel_out_o, rows[i][7:0], "table shift");
        end
        $display("test table done");
        // Shift clock held high gives one shift only
        sip_upstream_model_i.drive_run(1'b1, 4);
        check(parallel_out_o, 8'h36, "held clock");
        sip_upstream_model_i.drive_run(1'b0, 4);
        check(parallel_out_o, 8'h36, "serial change without edge");
        $display("test hold done");
        // Clear wins over a simultaneous rise, then shifting resumes
        sip_upstream_model_i.shift_bit(1'b1, 1'b1, 1'b0);
        check(parallel_out_o, 8'h00, "clear with edge");
        sip_upstream_model_i.shift_bit(1'b1, 1'b1, 1'b1);
        check(parallel_out_o, 8'h01, "resume after clear");
        sip_upstream_model_i.clear_hold(1, 1'b0);
        check(parallel_out_o, 8'h00, "zero shifted right after clear");
        sip_upstream_model_i.clear_hold(5, 1'b1);
        check(parallel_out_o, 8'h01, "held clear ignores shift edges");
        $display("test clear done");
        // Reset in mid-run with the shift clock high across release
        @(posedge clk_sys_i) #1 srst_i = 1'b1;
        sip_upstream_model_i.drive_run(1'b1, 2);
        srst_i = 1'b0;
        sip_upstream_model_i.drive_run(1'b1, 2);
        check(parallel_out_o, 8'h00, "no shift on a clock high at release");
        sip_upstream_model_i.drive_run(1'b0, 1);
        sip_upstream_model_i.shift_bit(1'b1, 1'b1, 1'b1);
        check(parallel_out_o, 8'h01, "shift after mid-run reset");
        $display("test mid-run reset done");
        final_report();
    end
endmodule
